/* ptr_defs.vh */
/*
 * Constants for the paper-tape reader controller: instruction codes,
 * register map, field positions and timing figures.
 * Assumes a 50 MHz system clock and is included by its bare name.
 */
`ifndef PTR_DEFS_VH
`define PTR_DEFS_VH

`define PTR_CLK_NS       20
`define PTR_CLK_KHZ      50000
`define PTR_T_START_US   5000
`define PTR_T_STEADY_US  1670
`define PTR_T_RAMP_US    333
`define PTR_T_CATCH_US   2600
`define PTR_T_HOLD_US    40000
`define PTR_T_ADV_NS     2000
`define PTR_T_STB_NS     100
`define PTR_US_CYC(t)    ((t) * `PTR_CLK_KHZ / 1000)
`define PTR_NS_CYC(t)    (((t) + `PTR_CLK_NS - 1) / `PTR_CLK_NS)

`define PTR_CW           24
`define PTR_CNT_ZERO     24'h000000
`define PTR_CNT_ONE      24'h000001
`define PTR_SC_W         8
`define PTR_SC_ZERO      8'h00
`define PTR_SC_ONE       8'h01

`define PTR_GRP_RDR      6'h01
`define PTR_GRP_PUN      6'h02
`define PTR_LO_ICON      3'h0
`define PTR_LO_SKIP      3'h1
`define PTR_LO_RRB_BIT   1
`define PTR_LO_RFC_BIT   2

`define PTR_PH_RESET     2'h0
`define PTR_PH_SYNC_A    2'h3
`define PTR_PH_SYNC_B    2'h0

`define PTR_REG_CTRL     4'h0
`define PTR_REG_STATUS   4'h4
`define PTR_REG_DATA     4'h8
`define PTR_CTRL_IE      0
`define PTR_ST_DONE      0
`define PTR_ST_REQ       1
`define PTR_ST_ENA       2
`define PTR_ST_HOLD      3
`define PTR_ST_PWR       4
`define PTR_ST_IE        5
`define PTR_ST_TAPE      6
`define PTR_ZERO32       32'h00000000

`endif

/* ptr_reader.v */
/*
 * Reader half of a paper-tape reader/punch controller: instruction
 * decode, step clock with start ramp, motor sequencing, character
 * buffer, done flag, interrupt and a small Avalon-MM register slave.
 * Assumes all bus and mechanism inputs are synchronous to mclk_i and
 * that each instruction holds io_pause_i high for exactly one cycle.
 */
// Functional notes
// - Decode select bits into reader, punch groups.
// - Either group asserts the internal-I/O claim.
// - Low bits give strobes; punch loads buffer.
// - Fetch instruction sets the request flip-flop.
// - Enable sets on request, no tick, hold.
// - Enable starts step clock and motor sequencer.
// - Tick, phase sync, feed hole give strobe.
// - Strobe captures eight tape bits.
// - Strobe clears the request flip-flop.
// - Strobe is followed by one advance step.
// - Each tick reloads enable from the request.
// - Enable fall waits 2.6 ms, then final step; manual feed skips both.
// - Stop hold 40 ms blocks enable setting.
// - Hold end removes power; first advance restores.
// - Steps clock two-bit phase; every second syncs.
// - Step period ramps from 5 to 1.67 ms.
// - Strobe sets the reader done flag.
// - Enabled interrupt plus done flag requests interrupt.
// - Read buffer drives data, asserts OR control.
// - Read buffer clears the done flag.
// - Interrupt-connect instruction sets interrupt enable.
// - Skip instruction skips when done flag set.
// - Fetch clears done; load sets it again.
// - No tape blocks fetch from setting request.
`include "ptr_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ptr_reader #(
    parameter [`PTR_CW-1:0] START_CYC  = `PTR_US_CYC(`PTR_T_START_US),
    parameter [`PTR_CW-1:0] STEADY_CYC = `PTR_US_CYC(`PTR_T_STEADY_US),
    parameter [`PTR_CW-1:0] RAMP_CYC   = `PTR_US_CYC(`PTR_T_RAMP_US),
    parameter [`PTR_CW-1:0] CATCH_CYC  = `PTR_US_CYC(`PTR_T_CATCH_US),
    parameter [`PTR_CW-1:0] HOLD_CYC   = `PTR_US_CYC(`PTR_T_HOLD_US)
) (
    input  wire        mclk_i,
    input  wire        rst_n_i,
    input  wire        io_pause_i,
    input  wire [5:0]  opcode_select_bits_i,
    input  wire [2:0]  opcode_low_bits_i,
    input  wire        bus_init_i,
    output reg         internal_io_o,
    output reg  [7:0]  reader_iot_o,
    output reg  [7:0]  punch_iot_o,
    output reg         punch_buffer_load_o,
    output reg         skip_o,
    output reg         ac_or_control_o,
    output reg  [7:0]  bus_data_o,
    output reg         bus_data_oe_o,
    output reg         interrupt_request_o,
    input  wire [7:0]  tape_bits_i,
    input  wire        feed_hole_i,
    input  wire        tape_present_i,
    input  wire        manual_feed_i,
    output reg         char_load_strobe_o,
    output reg         step_pulse_o,
    output reg  [1:0]  motor_phase_o,
    output reg         motor_power_o,
    output reg         motor_stop_hold_o,
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o
);

    localparam [`PTR_CW-1:0] ADV_CYC = `PTR_NS_CYC(`PTR_T_ADV_NS);
    localparam [`PTR_SC_W-1:0] STB_CYC = `PTR_NS_CYC(`PTR_T_STB_NS);

    reg                reader_request_ff;
    reg                reader_enable_ff;
    reg                reader_done_flag;
    reg                interrupt_enable_ff;
    reg                motor_power_ff;
    reg  [7:0]         buffer_r;
    reg  [1:0]         phase_r;
    reg  [`PTR_CW-1:0] tick_cnt_r;
    reg  [`PTR_CW-1:0] period_r;
    reg  [`PTR_CW-1:0] adv_cnt_r;
    reg                adv_pend_r;
    reg  [`PTR_CW-1:0] catch_cnt_r;
    reg                catch_pend_r;
    reg  [`PTR_CW-1:0] hold_cnt_r;
    reg                hold_r;
    reg  [`PTR_SC_W-1:0] stb_cnt_r;

    wire       rdr_grp, pun_grp, fetch_iot, rrb_iot;
    wire [7:0] rdr_dec, pun_dec;
    wire       tick, phase_sync, load_strobe, advance, hold_end;
    wire       final_step, step_pulse, ena_fall;
    wire       bus_req, bus_take, ie_wr;

    assign rdr_grp = io_pause_i & (opcode_select_bits_i == `PTR_GRP_RDR);
    assign pun_grp = io_pause_i & (opcode_select_bits_i == `PTR_GRP_PUN);
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_dec
            assign rdr_dec[g] = rdr_grp & (opcode_low_bits_i == g);
            assign pun_dec[g] = pun_grp & (opcode_low_bits_i == g);
        end
    endgenerate
    // Fetch and read-buffer are microcoded bits, so 6016 does both.
    assign fetch_iot = rdr_grp & opcode_low_bits_i[`PTR_LO_RFC_BIT];
    assign rrb_iot   = rdr_grp & opcode_low_bits_i[`PTR_LO_RRB_BIT];
    assign tick = reader_enable_ff & (tick_cnt_r == `PTR_CNT_ZERO);
    // sync on both equal phase codes
    assign phase_sync = (phase_r == `PTR_PH_SYNC_A) |
                        (phase_r == `PTR_PH_SYNC_B);
    assign load_strobe = tick & phase_sync & feed_hole_i;
    assign advance    = adv_pend_r & (adv_cnt_r == `PTR_CNT_ZERO);
    assign final_step = catch_pend_r & (catch_cnt_r == `PTR_CNT_ZERO);
    assign step_pulse = advance | final_step;
    assign hold_end   = hold_r & (hold_cnt_r == `PTR_CNT_ZERO);
    // enable drops only at a tick
    assign ena_fall = tick & ~reader_request_ff;

    assign bus_req  = avs_read_i | avs_write_i;
    assign bus_take = bus_req & ~avs_waitrequest_o;
    assign ie_wr    = bus_take & avs_write_i & avs_byteenable_i[0] &
                      (avs_address_i == `PTR_REG_CTRL);

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            internal_io_o       <= 1'b0;
            reader_iot_o        <= 8'h00;
            punch_iot_o         <= 8'h00;
            punch_buffer_load_o <= 1'b0;
            skip_o              <= 1'b0;
            ac_or_control_o     <= 1'b0;
            bus_data_o          <= 8'h00;
            bus_data_oe_o       <= 1'b0;
            interrupt_request_o <= 1'b0;
        end
        else
        begin
            internal_io_o       <= rdr_grp | pun_grp;
            reader_iot_o        <= rdr_dec;
            punch_iot_o         <= pun_dec;
            punch_buffer_load_o <= pun_grp;
            skip_o <= rdr_dec[`PTR_LO_SKIP] & reader_done_flag;
            ac_or_control_o <= rrb_iot;
            bus_data_oe_o   <= rrb_iot;
            bus_data_o      <= rrb_iot ? buffer_r : 8'h00;
            interrupt_request_o <= interrupt_enable_ff & reader_done_flag;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            interrupt_enable_ff <= 1'b0;
            reader_done_flag    <= 1'b0;
            reader_request_ff   <= 1'b0;
            buffer_r            <= 8'h00;
        end
        else
        begin
            // connect, initialize, software write; punch connect clears
            if (rdr_dec[`PTR_LO_ICON] | bus_init_i)
                interrupt_enable_ff <= 1'b1;
            else if (pun_dec[`PTR_LO_ICON])
                interrupt_enable_ff <= 1'b0;
            else if (ie_wr)
                interrupt_enable_ff <= avs_writedata_i[`PTR_CTRL_IE];
            // load sets done, winning over a clear
            if (load_strobe)
                reader_done_flag <= 1'b1;
            else if (rrb_iot | fetch_iot)
                reader_done_flag <= 1'b0;
            if (fetch_iot & tape_present_i)
                reader_request_ff <= 1'b1;
            else if (load_strobe)
                reader_request_ff <= 1'b0;
            if (load_strobe)
                buffer_r <= tape_bits_i;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reader_enable_ff <= 1'b0;
            tick_cnt_r       <= `PTR_CNT_ZERO;
            period_r         <= `PTR_CNT_ZERO;
        end
        else
        begin
            if (tick)
                reader_enable_ff <= reader_request_ff;
            // set only without tick or hold
            else if (reader_request_ff & ~hold_r)
                reader_enable_ff <= 1'b1;
            if (!reader_enable_ff)
            begin
                tick_cnt_r <= `PTR_CNT_ZERO;
                period_r   <= START_CYC;
            end
            else if (tick)
            begin
                tick_cnt_r <= period_r - `PTR_CNT_ONE;
                if (period_r > STEADY_CYC + RAMP_CYC)
                    period_r <= period_r - RAMP_CYC;
                else
                    period_r <= STEADY_CYC;
            end
            else
                tick_cnt_r <= tick_cnt_r - `PTR_CNT_ONE;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            adv_pend_r   <= 1'b0;
            adv_cnt_r    <= `PTR_CNT_ZERO;
            catch_pend_r <= 1'b0;
            catch_cnt_r  <= `PTR_CNT_ZERO;
            hold_r       <= 1'b0;
            hold_cnt_r   <= `PTR_CNT_ZERO;
        end
        else
        begin
            // advance follows a tick that keeps running
            if (tick & reader_request_ff)
            begin
                adv_pend_r <= 1'b1;
                adv_cnt_r  <= ADV_CYC - `PTR_CNT_ONE;
            end
            else if (advance)
                adv_pend_r <= 1'b0;
            else if (adv_pend_r)
                adv_cnt_r <= adv_cnt_r - `PTR_CNT_ONE;
            // catch delay, skipped under manual feed
            if (ena_fall & ~manual_feed_i)
            begin
                catch_pend_r <= 1'b1;
                catch_cnt_r  <= CATCH_CYC - `PTR_CNT_ONE;
            end
            else if (final_step)
                catch_pend_r <= 1'b0;
            else if (catch_pend_r)
                catch_cnt_r <= catch_cnt_r - `PTR_CNT_ONE;
            if (ena_fall)
            begin
                hold_r     <= 1'b1;
                hold_cnt_r <= HOLD_CYC - `PTR_CNT_ONE;
            end
            else if (hold_end)
                hold_r <= 1'b0;
            else if (hold_r)
                hold_cnt_r <= hold_cnt_r - `PTR_CNT_ONE;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase_r            <= `PTR_PH_RESET;
            motor_power_ff     <= 1'b0;
            step_pulse_o       <= 1'b0;
            motor_phase_o      <= `PTR_PH_RESET;
            motor_power_o      <= 1'b0;
            motor_stop_hold_o  <= 1'b0;
            char_load_strobe_o <= 1'b0;
            stb_cnt_r          <= `PTR_SC_ZERO;
        end
        else
        begin
            // gray walk so every second step lands on a sync code
            if (step_pulse)
                phase_r <= {phase_r[0], ~phase_r[1]};
            // first advance powers, hold end removes power
            if (advance)
                motor_power_ff <= 1'b1;
            else if (hold_end)
                motor_power_ff <= 1'b0;
            step_pulse_o      <= step_pulse;
            motor_phase_o     <= step_pulse ?
                                 {phase_r[0], ~phase_r[1]} : phase_r;
            motor_power_o     <= motor_power_ff | advance;
            // The pin drops with the last hold cycle, not one later.
            motor_stop_hold_o <= ena_fall | (hold_r & ~hold_end);
            // stretched to a narrow fixed width for the pins
            if (load_strobe)
            begin
                char_load_strobe_o <= 1'b1;
                stb_cnt_r          <= STB_CYC - `PTR_SC_ONE;
            end
            else if (stb_cnt_r != `PTR_SC_ZERO)
                stb_cnt_r <= stb_cnt_r - `PTR_SC_ONE;
            else
                char_load_strobe_o <= 1'b0;
        end
    end

    // One wait state per access keeps read data a clean register output.
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= `PTR_ZERO32;
        end
        else
        begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
            if (bus_req & avs_waitrequest_o & avs_read_i)
            begin
                avs_readdata_o <= `PTR_ZERO32;
                if (avs_address_i == `PTR_REG_CTRL)
                    avs_readdata_o[`PTR_CTRL_IE] <= interrupt_enable_ff;
                else if (avs_address_i == `PTR_REG_STATUS)
                begin
                    avs_readdata_o[`PTR_ST_DONE] <= reader_done_flag;
                    avs_readdata_o[`PTR_ST_REQ]  <= reader_request_ff;
                    avs_readdata_o[`PTR_ST_ENA]  <= reader_enable_ff;
                    avs_readdata_o[`PTR_ST_HOLD] <= hold_r;
                    avs_readdata_o[`PTR_ST_PWR]  <= motor_power_ff;
                    avs_readdata_o[`PTR_ST_IE]   <= interrupt_enable_ff;
                    avs_readdata_o[`PTR_ST_TAPE] <= tape_present_i;
                end
                else if (avs_address_i == `PTR_REG_DATA)
                    avs_readdata_o[7:0] <= buffer_r;
            end
        end
    end

endmodule

`default_nettype wire

/* ptr_reader_monitor.sv */
/* Port checker for the paper-tape reader controller.
   Assumes one clock, an async active-low reset and a bind at the top. */
`include "ptr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ptr_reader_monitor #(
    parameter [`PTR_CW-1:0] CATCH_CYC = `PTR_CNT_ONE,
    parameter [`PTR_CW-1:0] HOLD_CYC  = `PTR_CNT_ONE
) (
    input wire       mclk_i,
    input wire       rst_n_i,
    input wire       io_pause_i,
    input wire [5:0] opcode_select_bits_i,
    input wire [2:0] opcode_low_bits_i,
    input wire       manual_feed_i,
    input wire       internal_io_o,
    input wire [7:0] reader_iot_o,
    input wire [7:0] punch_iot_o,
    input wire       punch_buffer_load_o,
    input wire       skip_o,
    input wire       ac_or_control_o,
    input wire       bus_data_oe_o,
    input wire       char_load_strobe_o,
    input wire       step_pulse_o,
    input wire [1:0] motor_phase_o,
    input wire       motor_stop_hold_o
);
    wire [2:0] lo_w = opcode_low_bits_i;
    wire       rd_w = io_pause_i && opcode_select_bits_i == `PTR_GRP_RDR;
    wire       pn_w = io_pause_i && opcode_select_bits_i == `PTR_GRP_PUN;
    wire       sk_w = rd_w && lo_w == `PTR_LO_SKIP;
    reg  [`PTR_CW-1:0] hold_cnt_r;
    // A counter, since a 40 ms hold is far too long for a repetition.
    always @(posedge mclk_i or negedge rst_n_i)
        if (!rst_n_i)
            hold_cnt_r <= `PTR_CNT_ZERO;
        else if (motor_stop_hold_o)
            hold_cnt_r <= hold_cnt_r + `PTR_CNT_ONE;
        else
            hold_cnt_r <= `PTR_CNT_ZERO;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    grp_claim_a:
        assert property ((rd_w || pn_w) |=> internal_io_o)
        else $error("claim missing");
    no_claim_a:
        assert property (!(rd_w || pn_w) |=> !internal_io_o && !reader_iot_o)
        else $error("stray claim");
    rdr_dec_a:
        assert property (rd_w |=> reader_iot_o == 8'h01 << $past(lo_w))
        else $error("reader strobe wrong");
    pun_dec_a:
        assert property (pn_w |=> punch_buffer_load_o &&
            punch_iot_o == 8'h01 << $past(lo_w))
        else $error("punch strobe wrong");
    or_ctl_a:
        assert property (rd_w && lo_w[`PTR_LO_RRB_BIT] |=>
            ac_or_control_o && bus_data_oe_o)
        else $error("or control missing");
    skip_src_a:
        assert property (skip_o |-> $past(sk_w))
        else $error("skip without instruction");
    strobe_len_a:
        assert property ($rose(char_load_strobe_o) |->
            char_load_strobe_o [*5] ##1 !char_load_strobe_o)
        else $error("load strobe width");
    phase_step_a:
        assert property ($changed(motor_phase_o) |-> step_pulse_o)
        else $error("phase moved without step");
    hold_len_a:
        assert property ($fell(motor_stop_hold_o) |-> hold_cnt_r == HOLD_CYC)
        else $error("hold length wrong");
    final_step_a:
        assert property (step_pulse_o && motor_stop_hold_o |-> !manual_feed_i
            && hold_cnt_r + 1 >= CATCH_CYC && hold_cnt_r <= CATCH_CYC + 2)
        else $error("final step misplaced");
endmodule
bind ptr_reader ptr_reader_monitor #(
    .CATCH_CYC(CATCH_CYC), .HOLD_CYC(HOLD_CYC)
) u_mon (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .io_pause_i(io_pause_i),
    .opcode_select_bits_i(opcode_select_bits_i),
    .opcode_low_bits_i(opcode_low_bits_i), .manual_feed_i(manual_feed_i),
    .internal_io_o(internal_io_o), .reader_iot_o(reader_iot_o),
    .punch_iot_o(punch_iot_o), .punch_buffer_load_o(punch_buffer_load_o),
    .skip_o(skip_o), .ac_or_control_o(ac_or_control_o),
    .bus_data_oe_o(bus_data_oe_o), .char_load_strobe_o(char_load_strobe_o),
    .step_pulse_o(step_pulse_o), .motor_phase_o(motor_phase_o),
    .motor_stop_hold_o(motor_stop_hold_o)
);
`default_nettype wire

/* ptr_host_model.sv */
/* Processor side: issues one transfer instruction per call.
   Assumes the reader answers on the taking edge itself. */
`timescale 1ns/1ps
`default_nettype none
module ptr_host_model (
    input  wire       mclk_i,
    output reg        io_pause_o,
    output reg  [5:0] sel_o,
    output reg  [2:0] low_o
);
    initial
    begin
        io_pause_o = 1'b0;
        sel_o = 6'h00;
        low_o = 3'h0;
    end
    task iot(input logic [5:0] s, input logic [2:0] l);
    begin
        @(posedge mclk_i);
        io_pause_o <= 1'b1;
        sel_o <= s;
        low_o <= l;
        @(posedge mclk_i);
        io_pause_o <= 1'b0;
        // Released lines flip, so a stale opcode can never look valid.
        sel_o <= ~s;
        low_o <= ~l;
        #1;
    end
    endtask
endmodule
`default_nettype wire

/* tb.sv */
/* Self-checking bench for the paper-tape reader controller.
   Assumes the host model, the checker and shortened timer values. */
`include "ptr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
`define WT(c) while ((c) !== 1'b1) @(posedge mclk_i);
module tb;
    localparam int ST = 400, SD = 200, RP = 50, CA = 300, HO = 2000;
    reg mclk_i = 1'b0, rst_n_i = 1'b0, bus_init_i = 1'b0;
    reg manual_feed_i = 1'b0, tape_present_i = 1'b0, feed_hole_i = 1'b0;
    reg avs_read_i = 1'b0, avs_write_i = 1'b0;
    reg [7:0] tape_bits_i = 8'h00;
    reg [3:0] avs_address_i = 4'h0;
    reg [31:0] avs_writedata_i = 32'h00000000;
    wire io_pause_i, internal_io_o, punch_buffer_load_o, skip_o;
    wire ac_or_control_o, bus_data_oe_o, interrupt_request_o, motor_power_o;
    wire char_load_strobe_o, step_pulse_o, motor_stop_hold_o;
    wire avs_waitrequest_o;
    wire [5:0] opcode_select_bits_i;
    wire [2:0] opcode_low_bits_i;
    wire [7:0] reader_iot_o, punch_iot_o, bus_data_o;
    wire [1:0] motor_phase_o;
    wire [31:0] avs_readdata_o;
    int err_count = 0, compares = 0, cyc = 0, steps = 0, i, n0;
    int t [0:3];
    logic [31:0] q;
    logic [7:0] e;
    logic [5:0] s;
    ptr_host_model u_host (.mclk_i(mclk_i), .io_pause_o(io_pause_i),
        .sel_o(opcode_select_bits_i), .low_o(opcode_low_bits_i));
    ptr_reader #(.START_CYC(24'(ST)), .STEADY_CYC(24'(SD)),
        .RAMP_CYC(24'(RP)), .CATCH_CYC(24'(CA)), .HOLD_CYC(24'(HO))) u_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .io_pause_i(io_pause_i),
        .opcode_select_bits_i(opcode_select_bits_i),
        .opcode_low_bits_i(opcode_low_bits_i), .bus_init_i(bus_init_i),
        .internal_io_o(internal_io_o), .reader_iot_o(reader_iot_o),
        .punch_iot_o(punch_iot_o), .punch_buffer_load_o(punch_buffer_load_o),
        .skip_o(skip_o), .ac_or_control_o(ac_or_control_o),
        .bus_data_o(bus_data_o), .bus_data_oe_o(bus_data_oe_o),
        .interrupt_request_o(interrupt_request_o), .tape_bits_i(tape_bits_i),
        .feed_hole_i(feed_hole_i), .tape_present_i(tape_present_i),
        .manual_feed_i(manual_feed_i), .step_pulse_o(step_pulse_o),
        .char_load_strobe_o(char_load_strobe_o), .motor_phase_o(motor_phase_o),
        .motor_power_o(motor_power_o), .motor_stop_hold_o(motor_stop_hold_o),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o));
    always #10 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        feed_hole_i <= motor_phase_o == 2'h0 || motor_phase_o == 2'h3;
        if (step_pulse_o === 1'b1)
            steps <= steps + 1;
        if (cyc == 30000)
        begin
            err_count++;
            tally_and_finish;
        end
    end
    task tally_and_finish;
    begin
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    begin
        @(posedge mclk_i);
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_address_i <= a;
        avs_writedata_i <= d;
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    end
    endtask
    task t_decode;
    begin
        av(1'b0, `PTR_REG_STATUS, 32'h0);
        `CHK(q[5:0], 6'h00)
        for (i = 0; i < 24; i++)
        begin
            s = (i < 8) ? 6'h01 : (i < 16) ? 6'h02 : 6'h05;
            u_host.iot(s, i[2:0]);
            `CHK(internal_io_o, s != 6'h05)
            `CHK(reader_iot_o, s == 6'h01 ? 8'h01 << i[2:0] : 8'h00)
            `CHK(punch_iot_o, s == 6'h02 ? 8'h01 << i[2:0] : 8'h00)
            `CHK(punch_buffer_load_o, s == 6'h02)
        end
        u_host.iot(`PTR_GRP_RDR, 3'h4);
        repeat (20) @(posedge mclk_i);
        av(1'b0, `PTR_REG_STATUS, 32'h0);
        `CHK(q[2:1], 2'h0)
    end
    endtask
    task t_single;
    begin
        tape_present_i <= 1'b1;
        tape_bits_i <= 8'hA5;
        u_host.iot(`PTR_GRP_RDR, `PTR_LO_ICON);
        u_host.iot(`PTR_GRP_RDR, 3'h4);
        `WT(char_load_strobe_o)
        n0 = steps;
        av(1'b0, `PTR_REG_STATUS, 32'h0);
        `CHK(q[2:0], 3'h5)
        `CHK(interrupt_request_o, 1'b1)
        u_host.iot(`PTR_GRP_RDR, `PTR_LO_SKIP);
        `CHK(skip_o, 1'b1)
        u_host.iot(`PTR_GRP_RDR, 3'h2);
        `CHK(bus_data_o, 8'hA5)
        u_host.iot(`PTR_GRP_RDR, `PTR_LO_SKIP);
        `CHK(skip_o, 1'b0)
        `WT(motor_stop_hold_o)
        `CHK(motor_power_o, 1'b1)
        `WT(!motor_stop_hold_o)
        repeat (2) @(posedge mclk_i);
        `CHK(steps - n0, 2)
        `CHK(motor_phase_o, 2'h3)
        `CHK(motor_power_o, 1'b0)
    end
    endtask
    task t_stream;
    begin
        u_host.iot(`PTR_GRP_RDR, 3'h6);
        for (i = 0; i < 4; i++)
        begin
            `WT(char_load_strobe_o)
            t[i] = cyc;
            e = tape_bits_i;
            tape_bits_i <= tape_bits_i + 8'h11;
            u_host.iot(`PTR_GRP_RDR, 3'h6);
            `CHK(bus_data_o, e)
            `WT(!char_load_strobe_o)
        end
        `CHK(t[1] - t[0], 2 * ST - RP)
        `CHK(t[2] - t[1], 2 * ST - 5 * RP)
        `CHK(t[3] - t[2], 2 * SD)
    end
    endtask
    task t_hold;
    begin
        manual_feed_i <= 1'b1;
        `WT(motor_stop_hold_o)
        n0 = steps;
        u_host.iot(`PTR_GRP_RDR, 3'h4);
        av(1'b0, `PTR_REG_STATUS, 32'h0);
        `CHK(q[3:0], 4'hA)
        `WT(!motor_stop_hold_o)
        `CHK(steps - n0, 0)
        `WT(char_load_strobe_o)
        av(1'b0, `PTR_REG_STATUS, 32'h0);
        `CHK(q[0], 1'b1)
        manual_feed_i <= 1'b0;
    end
    endtask
    task t_regs;
    begin
        av(1'b0, 4'hC, 32'h0);
        `CHK(q, 32'h00000000)
        av(1'b1, `PTR_REG_CTRL, 32'h0);
        repeat (2) @(posedge mclk_i);
        `CHK(interrupt_request_o, 1'b0)
        bus_init_i <= 1'b1;
        @(posedge mclk_i);
        bus_init_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        `CHK(interrupt_request_o, 1'b1)
        av(1'b0, `PTR_REG_CTRL, 32'h0);
        `CHK(q[0], 1'b1)
        u_host.iot(`PTR_GRP_PUN, 3'h0);
        repeat (2) @(posedge mclk_i);
        `CHK(interrupt_request_o, 1'b0)
    end
    endtask
    initial
    begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_decode;
        t_single;
        t_stream;
        t_hold;
        t_regs;
        tally_and_finish;
    end
endmodule
`default_nettype wire
